// File: hw/lsl_loader.sv
// Serial-in parallel-out LED sink loader
// Function
// - A 16-bit shift register feeds a 16-bit output latch, one latch bit per sink channel.
// - On each serial clock rising edge the input bit enters stage 0 and other stages move on.
// - Serial out shows stage 15; strobe high latch follows, low holds; gate high blanks sinks.
// - With the active-low gate low, every channel whose latched bit is one is driven low.
`timescale 1ns/1ps
module lsl_loader
   import lsl_pkg::*;
(
   // System clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // Serial pins from host
   input wire logic serial_clk_i,
   input wire logic serial_in_i,
   input wire logic latch_strobe_i,
   input wire logic out_gate_n_i,
   // Cascade and sink outputs
   output logic serial_out_o,
   output logic [15:0] sink_channel_n_o
);
   logic sclk_s;
   logic sdat_s;
   logic strobe_s;
   logic gate_n_s;
   logic sclk_d_ff;
   logic nxt_sclk_d;
   logic [15:0] shift_ff;
   logic [15:0] nxt_shift;
   logic [15:0] latch_ff;
   logic [15:0] nxt_latch;
   logic [15:0] sink_n_ff;
   logic [15:0] nxt_sink_n;
   logic sout_ff;
   logic nxt_sout;
   logic sclk_rise;
   // Check helpers: rises since reset and the first bit taken
   logic [4:0] rise_cnt_ff;
   logic [4:0] nxt_rise_cnt;
   logic first_bit_ff;
   logic nxt_first_bit;

   // Synchronise every pin input
   lsl_sync u_sync_clk (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .pin_i(serial_clk_i),
      .sync_o(sclk_s)
   );
   lsl_sync u_sync_dat (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .pin_i(serial_in_i),
      .sync_o(sdat_s)
   );
   lsl_sync u_sync_stb (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .pin_i(latch_strobe_i),
      .sync_o(strobe_s)
   );
   lsl_sync u_sync_gate (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .pin_i(out_gate_n_i),
      .sync_o(gate_n_s)
   );

   // Rising edge of the serial clock
   assign sclk_rise = sclk_s & ~sclk_d_ff;

   // Delayed serial clock for edge detection
   // Reset value matches the idle pin level, so no false rise after reset
   always_comb begin
      nxt_sclk_d = sclk_s;
      if (srst_i) begin
         nxt_sclk_d = LSL_SCLK_IDLE;
      end
   end

   // Register the delayed serial clock
   always_ff @(posedge mclk_i) begin
      sclk_d_ff <= nxt_sclk_d;
   end

   // Next shift register: stage 0 takes the data pin, the rest move on
   always_comb begin
      nxt_shift = shift_ff;
      if (sclk_rise) begin
         nxt_shift = {shift_ff[LSL_LAST_STAGE-1:0], sdat_s};
      end
      if (srst_i) begin
         nxt_shift = LSL_SHIFT_RST;
      end
   end

   // Register the shift stages
   always_ff @(posedge mclk_i) begin
      shift_ff <= nxt_shift;
   end

   // Next latch: transparent while the strobe is high, else holds
   always_comb begin
      nxt_latch = latch_ff;
      if (strobe_s) begin
         nxt_latch = nxt_shift;
      end
      if (srst_i) begin
         nxt_latch = LSL_LATCH_RST;
      end
   end

   // Register the latch
   always_ff @(posedge mclk_i) begin
      latch_ff <= nxt_latch;
   end

   // Next cascade bit and sink drives
   always_comb begin
      nxt_sout = nxt_shift[LSL_LAST_STAGE];
      // One enables sink, which pulls low; gate high forces off
      nxt_sink_n = gate_n_s ? LSL_SINK_OFF : ~nxt_latch;
      if (srst_i) begin
         nxt_sout = LSL_BIT_RST;
         nxt_sink_n = LSL_SINK_OFF;
      end
   end

   // Register the outputs
   always_ff @(posedge mclk_i) begin
      sout_ff <= nxt_sout;
      sink_n_ff <= nxt_sink_n;
   end

   // Outputs come straight from flops
   assign serial_out_o = sout_ff;
   assign sink_channel_n_o = sink_n_ff;

   // Next helper values for the checks
   always_comb begin
      nxt_rise_cnt = rise_cnt_ff;
      nxt_first_bit = first_bit_ff;
      // Count saturates so it never wraps
      if (sclk_rise && rise_cnt_ff != LSL_RISE_FULL) begin
         nxt_rise_cnt = rise_cnt_ff + 5'h01;
      end
      if (sclk_rise && rise_cnt_ff == LSL_RISE_NONE) begin
         nxt_first_bit = sdat_s;
      end
      if (srst_i) begin
         nxt_rise_cnt = LSL_RISE_NONE;
         nxt_first_bit = LSL_BIT_RST;
      end
   end

   // Register the helpers
   always_ff @(posedge mclk_i) begin
      rise_cnt_ff <= nxt_rise_cnt;
      first_bit_ff <= nxt_first_bit;
   end

   // Reset checks
   a_reset_clears: assert property (@(posedge mclk_i)
      srst_i |=> shift_ff == LSL_SHIFT_RST && latch_ff == LSL_LATCH_RST)
      else $error("shift register or latch not cleared by reset");
   a_reset_outputs: assert property (@(posedge mclk_i)
      srst_i |=> sink_channel_n_o == LSL_SINK_OFF && serial_out_o == LSL_BIT_RST)
      else $error("outputs not at rest after reset");

   // Shift and cascade checks
   a_shift_moves: assert property (@(posedge mclk_i) disable iff (srst_i)
      sclk_rise |=> shift_ff == {$past(shift_ff[LSL_LAST_STAGE-1:0]), $past(sdat_s)})
      else $error("shift register did not advance on serial clock");
   a_shift_holds: assert property (@(posedge mclk_i) disable iff (srst_i)
      !sclk_rise |=> $stable(shift_ff))
      else $error("shift register moved without serial clock edge");
   a_first_bit: assert property (@(posedge mclk_i) disable iff (srst_i)
      sclk_rise ##1 (!sclk_rise [*2]) |-> shift_ff[0] == $past(sdat_s, 2))
      else $error("first stage lost incoming bit");
   a_first_lands: assert property (@(posedge mclk_i) disable iff (srst_i)
      sclk_rise && rise_cnt_ff == LSL_RISE_LAST |=> shift_ff[LSL_LAST_STAGE] == first_bit_ff)
      else $error("first bit did not reach channel 15 after sixteen rises");
   a_serial_out: assert property (@(posedge mclk_i) disable iff (srst_i)
      serial_out_o == shift_ff[LSL_LAST_STAGE])
      else $error("serial out differs from last stage");
   a_cascade_bit: assert property (@(posedge mclk_i) disable iff (srst_i)
      sclk_rise |=> serial_out_o == $past(shift_ff[LSL_LAST_STAGE-1]))
      else $error("serial out did not take the stage below it");

   // Latch and sink checks
   a_latch_follow: assert property (@(posedge mclk_i) disable iff (srst_i)
      strobe_s |=> latch_ff == shift_ff)
      else $error("latch not following with strobe high");
   a_latch_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
      !strobe_s |=> $stable(latch_ff))
      else $error("latch changed with strobe low");
   a_gate_off: assert property (@(posedge mclk_i) disable iff (srst_i)
      gate_n_s |=> sink_channel_n_o == LSL_SINK_OFF)
      else $error("sinks on while gate high");
   a_sink_on: assert property (@(posedge mclk_i) disable iff (srst_i)
      !gate_n_s |=> sink_channel_n_o == ~latch_ff)
      else $error("sink pattern differs from latch");
   a_sink_follow: assert property (@(posedge mclk_i) disable iff (srst_i)
      strobe_s && !gate_n_s |=> sink_channel_n_o == ~shift_ff)
      else $error("sinks not following shift register with strobe high");

   // Main scenarios
   c_shift: cover property (@(posedge mclk_i) disable iff (srst_i) sclk_rise);
   c_capture: cover property (@(posedge mclk_i) disable iff (srst_i)
      strobe_s ##1 !strobe_s);
   c_lit: cover property (@(posedge mclk_i) disable iff (srst_i)
      !gate_n_s && sink_channel_n_o != LSL_SINK_OFF);
   c_follow: cover property (@(posedge mclk_i) disable iff (srst_i)
      strobe_s && sclk_rise);
   c_blank: cover property (@(posedge mclk_i) disable iff (srst_i)
      gate_n_s && latch_ff != LSL_LATCH_RST);
endmodule

// File: hw/lsl_pkg.sv
// Package of constants for the LED sink serial loader
package lsl_pkg;
   localparam int LSL_CHANNELS = 16;
   localparam logic [15:0] LSL_SHIFT_RST = 16'h0000;
   localparam logic [15:0] LSL_LATCH_RST = 16'h0000;
   localparam logic [15:0] LSL_SINK_OFF = 16'hFFFF;
   localparam logic [1:0] LSL_SYNC_RST = 2'h0;
   localparam int LSL_LAST_STAGE = 15;
   localparam logic LSL_SCLK_IDLE = 1'h0;
   localparam logic LSL_BIT_RST = 1'h0;
   localparam logic [4:0] LSL_RISE_NONE = 5'h00;
   localparam logic [4:0] LSL_RISE_LAST = 5'h0F;
   localparam logic [4:0] LSL_RISE_FULL = 5'h10;
endpackage

// File: hw/lsl_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lsl_sync
   import lsl_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic srst_i,
   // Pin level in, synchronised level out
   input wire logic pin_i,
   output logic sync_o
);
   logic [1:0] stage_ff;
   logic [1:0] nxt_stage;

   // Next stage values
   always_comb begin
      nxt_stage = {stage_ff[0], pin_i};
      if (srst_i) begin
         nxt_stage = LSL_SYNC_RST;
      end
   end

   // Register the stages
   always_ff @(posedge mclk_i) begin
      stage_ff <= nxt_stage;
   end

   assign sync_o = stage_ff[1];
endmodule

// File: bench/lsl_host.sv
// Host model that drives the loader's serial pins
`timescale 1ns/1ps
module lsl_host (
   // Clock
   input wire logic mclk_i,
   // Pins to loader
   output logic serial_clk_o,
   output logic serial_in_o,
   output logic latch_strobe_o,
   output logic out_gate_n_o
);
   // Idle pin levels
   initial begin
      serial_clk_o = 1'b0;
      serial_in_o = 1'b1;
      latch_strobe_o = 1'b0;
      out_gate_n_o = 1'b1;
   end
   // Shift n bits, highest first, with data settled 3 edges each side of the rise
   task automatic send(input logic [15:0] w, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge mclk_i) serial_in_o <= w[i];
         repeat (3) @(posedge mclk_i);
         serial_clk_o <= 1'b1;
         repeat (3) @(posedge mclk_i);
         serial_clk_o <= 1'b0;
         serial_in_o <= ~w[i]; // Released line shows the inverse
      end
   endtask
   // Set strobe and gate levels
   task automatic pins(input logic strobe_lvl, input logic gate_n);
      @(posedge mclk_i);
      latch_strobe_o <= strobe_lvl;
      out_gate_n_o <= gate_n;
   endtask
endmodule

// File: bench/tb_lsl_loader.sv
// Testbench for the LED sink serial loader
`timescale 1ns/1ps
module tb_lsl_loader import lsl_pkg::*; ;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic sck, sdat, strobe, gate_n, s_out;
   logic [15:0] sink_n;
   int err_total = 0;
   int n_checks = 0;
   always #5 mclk_i = ~mclk_i;
   lsl_host u_lsl_host (.mclk_i(mclk_i), .serial_clk_o(sck), .serial_in_o(sdat),
      .latch_strobe_o(strobe), .out_gate_n_o(gate_n));
   lsl_loader u_lsl_loader (.mclk_i(mclk_i), .srst_i(srst_i), .serial_clk_i(sck),
      .serial_in_i(sdat), .latch_strobe_i(strobe), .out_gate_n_i(gate_n),
      .serial_out_o(s_out), .sink_channel_n_o(sink_n));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Let pin changes pass the synchronisers
   task automatic settle();
      repeat (6) @(posedge mclk_i);
      #1;
   endtask
   // Strobe high 3 cycles then low
   task automatic pulse(input logic g);
      u_lsl_host.pins(1'b1, g);
      repeat (2) @(posedge mclk_i);
      u_lsl_host.pins(1'b0, g);
   endtask
   task automatic t_reset();
      settle();
      chk(sink_n, LSL_SINK_OFF);
      chk_bit(s_out, 1'h0);
   endtask
   // Channels 0,3,4,5,10,13,15 lit
   task automatic t_load();
      u_lsl_host.send(16'hA439, 16);
      pulse(1'b1);
      u_lsl_host.pins(1'b0, 1'b0);
      settle();
      chk(sink_n, ~16'hA439);
      chk_bit(s_out, 1'h1);
   endtask
   // Latch holds while strobe low; gate high blanks
   task automatic t_hold();
      u_lsl_host.send(16'h1234, 16);
      settle();
      chk(sink_n, ~16'hA439);
      chk_bit(s_out, 1'h0);
      u_lsl_host.pins(1'b0, 1'b1);
      settle();
      chk(sink_n, 16'hFFFF);
      pulse(1'b0);
      settle();
      chk(sink_n, ~16'h1234);
   endtask
   // Strobe held high: latch follows each shift
   task automatic t_follow();
      u_lsl_host.pins(1'b1, 1'b0);
      u_lsl_host.send(16'h0005, 3);
      settle();
      chk(sink_n, ~16'h91A5);
      chk_bit(s_out, 1'h1);
   endtask
   initial begin
      repeat (10) @(posedge mclk_i);
      srst_i <= 1'b0;
      t_reset();
      t_load();
      t_hold();
      t_follow();
      wrap_up();
   end
   initial begin
      #50000;
      err_total++;
      wrap_up();
   end
endmodule
